// ---- rtl/cis_pkg.sv ----
// Package for the configuration initialization sequencer
// Shared offsets, field positions, reset values and timing counts
package cis_pkg;

  // System clock
  localparam int unsigned ClkFreqHz       = 50000000;
  // Internal oscillator, typical
  localparam int unsigned OscFreqHz       = 10000000;
  localparam int unsigned OscDivCount     = ClkFreqHz / OscFreqHz;
  // Initialization clock cycles after the loaded flag
  localparam int unsigned InitCycles      = 3185;
  // Reset time-out after an error, in microseconds
  localparam int unsigned ErrTimeoutUs    = 100;
  localparam int unsigned ErrTimeoutCyc   = ErrTimeoutUs * (ClkFreqHz / 1000000);

  // Register offsets (byte addresses)
  localparam logic [7:0] RegCtrl   = 8'h00;
  localparam logic [7:0] RegStatus = 8'h04;
  localparam logic [7:0] RegIrq    = 8'h08;
  localparam logic [7:0] RegMask   = 8'h0c;

  // Control field positions
  localparam int unsigned CtrlUserClk   = 0;
  localparam int unsigned CtrlInitDone  = 1;
  localparam int unsigned CtrlAutoRst   = 2;
  localparam int unsigned CtrlCompress  = 3;
  localparam int unsigned CtrlRestart   = 4;
  localparam logic [4:0]  CtrlReset     = 5'h00;

  // Event bit positions
  localparam int unsigned EvUserMode = 0;
  localparam int unsigned EvError    = 1;
  localparam int unsigned EvRelease  = 2;
  localparam logic [2:0]  MaskReset  = 3'h0;

  // Bus answer codes
  localparam logic [1:0] RespOkay   = 2'h0;
  localparam logic [1:0] RespSlvErr = 2'h2;

  typedef enum logic [1:0] {CisLoad, CisInit, CisUser, CisError} cis_state_e;

endpackage

// ---- rtl/cis_decomp.sv ----
// Serial bitstream front end with optional run-length decompression
// Assumes bits arrive one per cycle with a valid strobe, synchronous to mclk
`timescale 1ns/10ps
module cis_decomp
  import cis_pkg::*;
#(
  parameter int unsigned RunWidth = 4
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic clr,
  // Control
  input  wire logic compressEn,
  // Input stream
  input  wire logic inValid,
  input  wire logic inBit,
  output logic      inReady,
  // Output stream
  output logic      outValid,
  output logic      outBit
);

  // A compressed symbol is RunWidth bits of count then one data bit
  logic [RunWidth-1:0] runCnt_q, runCnt_d;
  logic [RunWidth-1:0] hdrCnt_q, hdrCnt_d;
  logic [RunWidth-1:0] hdr_q, hdr_d;
  logic                repBit_q, repBit_d;
  logic                outValid_d, outBit_d;
  logic                needBit;

  assign inReady = (runCnt_q == '0);
  assign needBit = hdrCnt_q == RunWidth[RunWidth-1:0];

  always_comb
  begin
    runCnt_d   = runCnt_q;
    hdrCnt_d   = hdrCnt_q;
    hdr_d      = hdr_q;
    repBit_d   = repBit_q;
    outValid_d = 1'b0;
    outBit_d   = outBit;
    if (clr)
    begin
      runCnt_d = '0;
      hdrCnt_d = '0;
    end
    else if (runCnt_q != '0)
    begin
      runCnt_d   = runCnt_q - 1'b1;
      outValid_d = 1'b1;
      outBit_d   = repBit_q;
    end
    else if (inValid)
    begin
      if (!compressEn)
      begin
        outValid_d = 1'b1;
        outBit_d   = inBit;
      end
      else if (!needBit)
      begin
        hdr_d    = {hdr_q[RunWidth-2:0], inBit};
        hdrCnt_d = hdrCnt_q + 1'b1;
      end
      else
      begin
        // Emit first copy now, the rest from the run counter
        outValid_d = 1'b1;
        outBit_d   = inBit;
        repBit_d   = inBit;
        runCnt_d   = hdr_q;
        hdrCnt_d   = '0;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      runCnt_q <= '0;
      hdrCnt_q <= '0;
      hdr_q    <= '0;
      repBit_q <= 1'b0;
      outValid <= 1'b0;
      outBit   <= 1'b0;
    end
    else
    begin
      runCnt_q <= runCnt_d;
      hdrCnt_q <= hdrCnt_d;
      hdr_q    <= hdr_d;
      repBit_q <= repBit_d;
      outValid <= outValid_d;
      outBit   <= outBit_d;
    end
  end

endmodule // cis_decomp

// ---- rtl/cis_sequencer.sv ----
// Configuration initialization sequencer with AXI4-Lite control registers
// Assumes all inputs synchronous to mclk; open-drain pins resolved outside
//
// Overview of operation
// RULE1: Initialization clock defaults to internal oscillator, 10 MHz typical.
// RULE2: Option picks internal oscillator or user start-up clock pin.
// RULE3: After loaded flag high, run 3185 init clocks, then user mode.
// RULE4: User start-up clock affects only initialization, not data loading.
// RULE5: Unselected user start-up clock pin serves as ordinary user pin.
// RULE6: Init-done goes low to high exactly when user mode begins.
// RULE7: Init-done exists only if enabled; open-drain, pulls low only.
// RULE8: With auto-restart, error pulls status low and resets config logic.
// RULE9: After reset time-out, status pin released for pull-up.
// RULE10: Host waits for status high after error before resending data.
// RULE11: Serial schemes accept compressed bitstream, decompressed on the fly.
// RULE12: Init counter clears on restart, counts selected clock after loaded.
`timescale 1ns/10ps
module cis_sequencer
  import cis_pkg::*;
#(
  parameter int unsigned InitCount  = InitCycles,
  parameter int unsigned ErrTimeout = ErrTimeoutCyc
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Configuration data stream
  input  wire logic        cfgValid,
  input  wire logic        cfgBit,
  output logic             cfgReady,
  output logic             loadValid,
  output logic             loadBit,
  input  wire logic        cfgError,
  input  wire logic        configLoadedFlag,
  // User start-up clock pin, sampled as a level
  input  wire logic        userStartupClockIn,
  output logic             userStartupClockOut,
  output logic             userStartupClockOe,
  input  wire logic        userIoOut,
  input  wire logic        userIoOe,
  output logic             userIoIn,
  // Open-drain init-done pin
  output logic             initDoneOut,
  output logic             initDoneOe,
  // Open-drain status pin
  input  wire logic        configStatusNIn,
  output logic             configStatusNOut,
  output logic             configStatusNOe,
  // Status
  output logic             userMode,
  output logic             irq
);

  cis_state_e  state_q, state_d;
  logic [4:0]  ctrl_q, ctrl_d;
  logic [2:0]  irqStat_q, irqStat_d;
  logic [2:0]  mask_q, mask_d;
  logic [11:0] initCnt_q, initCnt_d;
  logic [31:0] errCnt_q, errCnt_d;
  logic [2:0]  oscDiv_q, oscDiv_d;
  logic        usrClk_q, usrClk_d;
  logic        awHave_q, awHave_d, wHave_q, wHave_d;
  logic [7:0]  awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0]  wStrb_q, wStrb_d;
  logic        bValid_d, rValid_d;
  logic [31:0] rData_d;
  logic [1:0]  bResp_d, rResp_d;
  logic        oscTick, usrTick, initTick, doWrite, doRead, restart;
  logic [2:0]  events;

  function automatic logic addrOk(input logic [7:0] a);
    if (a == RegCtrl) return 1'b1;
    else if (a == RegStatus) return 1'b1;
    else if (a == RegIrq) return 1'b1;
    else if (a == RegMask) return 1'b1;
    else return 1'b0;
  endfunction

  // RULE1: oscillator divider
  assign oscTick  = (oscDiv_q == 3'(OscDivCount - 1));
  // RULE2: rising edge of sampled user clock
  assign usrTick  = userStartupClockIn & ~usrClk_q;
  // RULE2: clock source select
  assign initTick = ctrl_q[CtrlUserClk] ? usrTick : oscTick;

  // RULE5: pin is plain user I/O when not the start-up clock
  assign userStartupClockOut = userIoOut;
  assign userStartupClockOe  = userIoOe & ~ctrl_q[CtrlUserClk];
  assign userIoIn            = ctrl_q[CtrlUserClk] ? 1'b0 : userStartupClockIn;

  assign userMode = (state_q == CisUser);
  // RULE6: init-done released when user mode starts
  // RULE7: open drain, only drives low, only when enabled
  assign initDoneOut = 1'b0;
  assign initDoneOe  = ctrl_q[CtrlInitDone] & ~userMode;
  // RULE8: status pin pulled low during error recovery
  assign configStatusNOut = 1'b0;
  assign configStatusNOe  = (state_q == CisError);

  assign irq = |(irqStat_q & mask_q);

  // RULE4: loading path independent of start-up clock selection
  // RULE11: compressed stream decoded on the fly
  cis_decomp u_decomp (
    .mclk       (mclk),
    .rstn       (rstn),
    .clr        (restart),
    .compressEn (ctrl_q[CtrlCompress]),
    .inValid    (cfgValid & (state_q == CisLoad)),
    .inBit      (cfgBit),
    .inReady    (cfgReady),
    .outValid   (loadValid),
    .outBit     (loadBit)
  );

  // Bus handshakes
  assign s_axi_awready = ~awHave_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHave_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign doWrite = awHave_q & wHave_q & ~s_axi_bvalid;
  assign doRead  = s_axi_arvalid & s_axi_arready;
  assign restart = doWrite && (awAddr_q == RegCtrl) && wStrb_q[0] && wData_q[CtrlRestart];

  always_comb
  begin
    awHave_d = awHave_q;
    wHave_d  = wHave_q;
    awAddr_d = awAddr_q;
    wData_d  = wData_q;
    wStrb_d  = wStrb_q;
    bValid_d = s_axi_bvalid & ~s_axi_bready;
    bResp_d  = s_axi_bresp;
    rValid_d = s_axi_rvalid & ~s_axi_rready;
    rData_d  = s_axi_rdata;
    rResp_d  = s_axi_rresp;
    ctrl_d   = ctrl_q;
    mask_d   = mask_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      awHave_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wHave_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (doWrite)
    begin
      awHave_d = 1'b0;
      wHave_d  = 1'b0;
      bValid_d = 1'b1;
      bResp_d  = addrOk(awAddr_q) ? RespOkay : RespSlvErr;
      if (wStrb_q[0])
      begin
        if (awAddr_q == RegCtrl)
          ctrl_d = {1'b0, wData_q[3:0]};
        else if (awAddr_q == RegMask)
          mask_d = wData_q[2:0];
      end
    end
    if (doRead)
    begin
      rValid_d = 1'b1;
      rResp_d  = addrOk(s_axi_araddr) ? RespOkay : RespSlvErr;
      rData_d  = '0;
      if (s_axi_araddr == RegCtrl)
        rData_d = {27'h0, ctrl_q};
      else if (s_axi_araddr == RegStatus)
        rData_d = {16'h0, initCnt_q, 2'h0, 2'(state_q)} | (32'(configStatusNIn) << 4);
      else if (s_axi_araddr == RegIrq)
        rData_d = {29'h0, irqStat_q};
      else if (s_axi_araddr == RegMask)
        rData_d = {29'h0, mask_q};
    end
  end

  // Sequencer
  always_comb
  begin
    state_d   = state_q;
    initCnt_d = initCnt_q;
    errCnt_d  = errCnt_q;
    oscDiv_d  = oscTick ? 3'h0 : oscDiv_q + 3'h1;
    usrClk_d  = userStartupClockIn;
    events    = 3'h0;
    case (state_q)
      CisLoad:
      begin
        initCnt_d = '0;
        // RULE8: auto-restart on error
        if (cfgError && ctrl_q[CtrlAutoRst])
        begin
          state_d  = CisError;
          errCnt_d = '0;
          events[EvError] = 1'b1;
        end
        else if (configLoadedFlag)
          state_d = CisInit;
      end
      CisInit:
      begin
        // RULE12: count only selected init clock edges
        // RULE3: fixed init length
        if (initTick)
        begin
          if (initCnt_q == 12'(InitCount - 1))
          begin
            state_d = CisUser;
            events[EvUserMode] = 1'b1;
          end
          initCnt_d = initCnt_q + 12'h1;
        end
      end
      CisUser:
        state_d = CisUser;
      CisError:
      begin
        // RULE9: release after time-out
        errCnt_d = errCnt_q + 32'h1;
        if (errCnt_q == ErrTimeout - 1)
        begin
          state_d = CisLoad;
          events[EvRelease] = 1'b1;
        end
      end
      default:
        state_d = CisLoad;
    endcase
    // RULE12: restart clears counter and reloads
    if (restart)
    begin
      state_d   = CisLoad;
      initCnt_d = '0;
    end
    // Event set wins over read clear
    irqStat_d = ((doRead && s_axi_araddr == RegIrq) ? 3'h0 : irqStat_q) | events;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      state_q      <= CisLoad;
      ctrl_q       <= CtrlReset;
      mask_q       <= MaskReset;
      irqStat_q    <= 3'h0;
      initCnt_q    <= '0;
      errCnt_q     <= '0;
      oscDiv_q     <= 3'h0;
      usrClk_q     <= 1'b0;
      awHave_q     <= 1'b0;
      wHave_q      <= 1'b0;
      awAddr_q     <= 8'h00;
      wData_q      <= 32'h0;
      wStrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RespOkay;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RespOkay;
    end
    else
    begin
      state_q      <= state_d;
      ctrl_q       <= ctrl_d;
      mask_q       <= mask_d;
      irqStat_q    <= irqStat_d;
      initCnt_q    <= initCnt_d;
      errCnt_q     <= errCnt_d;
      oscDiv_q     <= oscDiv_d;
      usrClk_q     <= usrClk_d;
      awHave_q     <= awHave_d;
      wHave_q      <= wHave_d;
      awAddr_q     <= awAddr_d;
      wData_q      <= wData_d;
      wStrb_q      <= wStrb_d;
      s_axi_bvalid <= bValid_d;
      s_axi_bresp  <= bResp_d;
      s_axi_rvalid <= rValid_d;
      s_axi_rdata  <= rData_d;
      s_axi_rresp  <= rResp_d;
    end
  end

endmodule // cis_sequencer

// ---- sim/cis_seq_props.sv ----
// Port checker for the initialization sequencer
// Bound into every sequencer instance; single clock domain
`timescale 1ns/10ps
module cis_seq_props
  import cis_pkg::*;
#(
  parameter int unsigned InitCount  = InitCycles,
  parameter int unsigned ErrTimeout = ErrTimeoutCyc
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rstn,
  // Stream and pins
  input wire logic        cfgError,
  input wire logic        configLoadedFlag,
  input wire logic        userIoOe,
  input wire logic        userStartupClockOe,
  input wire logic        initDoneOut,
  input wire logic        initDoneOe,
  input wire logic        configStatusNOut,
  input wire logic        configStatusNOe,
  input wire logic        userMode,
  // Bus answers
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  logic [15:0] errCnt_q;
  logic [15:0] errCnt_d;
  logic [15:0] loadCnt_q;
  logic [15:0] loadCnt_d;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // Length of the current status pull-down
  always_comb errCnt_d = configStatusNOe ? errCnt_q + 16'h1 : 16'h0;
  always_ff @(posedge mclk) errCnt_q <= rstn ? errCnt_d : 16'h0;
  // Cycles the loaded flag has stood high, saturating
  always_comb loadCnt_d = !configLoadedFlag ? 16'h0 : loadCnt_q + 16'(loadCnt_q != 16'hffff);
  always_ff @(posedge mclk) loadCnt_q <= rstn ? loadCnt_d : 16'h0;

  a_drain_only: assert property (!initDoneOut && !configStatusNOut)
    else $error("open-drain pin driven high");
  a_done_not_user: assert property (initDoneOe |-> !userMode)
    else $error("init-done held low in user mode");
  a_done_release: assert property ($fell(initDoneOe) |-> userMode)
    else $error("init-done released outside user mode");
  a_err_pulls: assert property ($rose(configStatusNOe) |-> $past(cfgError))
    else $error("status pulled low without error");
  a_err_no_user: assert property (configStatusNOe |-> !userMode)
    else $error("user mode during error reset");
  a_err_timeout: assert property ($fell(configStatusNOe) |-> errCnt_q == 16'(ErrTimeout))
    else $error("status released at wrong time");
  // Each init clock edge needs at least two system cycles
  a_init_wait: assert property ($rose(userMode) |-> loadCnt_q >= 16'(2 * InitCount))
    else $error("user mode too soon after loaded flag");
  a_pin_user_io: assert property (userStartupClockOe |-> userIoOe)
    else $error("start-up clock pin driven unasked");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");

  c_user: cover property ($rose(userMode));
  c_release: cover property ($fell(configStatusNOe));
  c_rstall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule // cis_seq_props

bind cis_sequencer cis_seq_props #(.InitCount(InitCount), .ErrTimeout(ErrTimeout))
  i_cis_seq_props (.mclk(mclk), .rstn(rstn), .cfgError(cfgError),
  .configLoadedFlag(configLoadedFlag), .userIoOe(userIoOe),
  .userStartupClockOe(userStartupClockOe), .initDoneOut(initDoneOut),
  .initDoneOe(initDoneOe), .configStatusNOut(configStatusNOut),
  .configStatusNOe(configStatusNOe), .userMode(userMode),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// ---- sim/cis_host_model.sv ----
// Configuration host: streams bits, may inject one error
// Assumes a pulled-up status line; waits while start is held
`timescale 1ns/10ps
module cis_host_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Bench command
  input  wire logic        start,
  input  wire logic        withErr,
  input  wire logic [15:0] pat,
  input  wire logic [4:0]  len,
  output logic             busy,
  // Device side
  input  wire logic        cfgReady,
  input  wire logic        statLine,
  output logic             cfgValid,
  output logic             cfgBit,
  output logic             cfgError,
  output logic             cfgLoaded
);
  int   i;
  int   k;
  logic e;
  initial
  begin
    {busy, cfgValid, cfgBit, cfgError, cfgLoaded} = 5'h00;
    forever
    begin
      @(posedge mclk);
      if (start && rstn)
      begin
        busy <= 1'b1;
        cfgLoaded <= 1'b0;
        e = withErr;
        i = 0;
        while (start) @(posedge mclk);
        while (i < len)
        begin
          cfgValid <= 1'b1;
          cfgBit <= pat[len-1-i];
          @(posedge mclk);
          if (cfgReady) i++;
          if (e && i == 2)
          begin
            cfgValid <= 1'b0;
            cfgBit <= ~cfgBit;
            cfgError <= 1'b1;
            @(posedge mclk);
            cfgError <= 1'b0;
            for (k = 0; k < 50 && statLine; k++) @(posedge mclk);
            for (k = 0; k < 300 && !statLine; k++) @(posedge mclk);
            e = 1'b0;
            i = 0;
          end
        end
        cfgValid <= 1'b0;
        cfgBit <= ~cfgBit;
        cfgLoaded <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule // cis_host_model

// ---- sim/cis_sequencer_tb.sv ----
// Bench for the initialization sequencer
// Drives the register bus, pins and host model; clock 50 MHz
`timescale 1ns/10ps
module cis_sequencer_tb;
  import cis_pkg::*;
  localparam int unsigned NInit = 8;
  localparam int unsigned NErr  = 10;
  logic        mclk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic        cfgValid, cfgBit, cfgReady, loadValid, loadBit, cfgError, cfgLoaded;
  logic        usrOut, usrOe, userIoOut, userIoOe, userIoIn, pinDrv, irq;
  logic        initDoneOut, initDoneOe, configStatusNOut, configStatusNOe, userMode;
  logic        start, withErr, busy;
  logic [15:0] pat, seed, got;
  logic [4:0]  len;
  int          errTotal, nChecks, nLoad, k, n;
  wire         statLine = !configStatusNOe;
  wire         doneLine = initDoneOe ? initDoneOut : 1'b1;
  wire         usrPin   = usrOe ? usrOut : pinDrv;

  cis_sequencer #(.InitCount(NInit), .ErrTimeout(NErr)) i_cis_sequencer (.mclk, .rstn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cfgValid, .cfgBit, .cfgReady, .loadValid, .loadBit,
    .cfgError, .configLoadedFlag(cfgLoaded), .userStartupClockIn(usrPin),
    .userStartupClockOut(usrOut), .userStartupClockOe(usrOe), .userIoOut, .userIoOe,
    .userIoIn, .initDoneOut, .initDoneOe, .configStatusNIn(statLine),
    .configStatusNOut, .configStatusNOe, .userMode, .irq);
  cis_host_model i_cis_host_model (.mclk, .rstn, .start, .withErr, .pat, .len, .busy,
    .cfgReady, .statLine, .cfgValid, .cfgBit, .cfgError, .cfgLoaded);

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) if (loadValid === 1'b1) {got, nLoad} <= {got[14:0], loadBit, nLoad + 1};

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic completeRun();
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (e !== g)
    begin
      errTotal++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic limit(input int c, input int m);
    if (c >= m)
    begin
      chk("wait bound", 0, 1);
      completeRun();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    @(posedge mclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
    for (k = 0; k < 40; k++)
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) break;
      {s_axi_bready, s_axi_rready} <= {s_axi_bvalid, s_axi_rvalid};
    end
    {s_axi_bready, s_axi_rready} <= 2'b00;
    limit(k, 40);
    chk("resp", e, w ? s_axi_bresp : s_axi_rresp);
    if (!w) chk("rdata", d, s_axi_rdata);
  endtask
  task automatic arm(input logic [15:0] p, input logic [4:0] l, input logic e);
    @(posedge mclk);
    {pat, len, withErr, start, got, nLoad} <= {p, l, e, 1'b1, 16'h0, 32'd0};
    // Second edge lets the host raise busy before anyone waits on it
    repeat (2) @(posedge mclk);
  endtask
  task automatic waitFor(input logic lvl);
    for (n = 0; n < 400 && (lvl ? userMode : busy) !== lvl; n++) @(posedge mclk);
    limit(n, 400);
  endtask

  initial
  begin
    {rstn, start, withErr, pat, len, pinDrv, userIoOut, userIoOe} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hf};
    {errTotal, nChecks, seed} = {32'd0, 32'd0, 16'h40bb};
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    bus(0, RegCtrl, 0, RespOkay);
    bus(0, RegMask, 0, RespOkay);
    bus(0, 8'h10, 0, RespSlvErr);
    bus(1, 8'h10, 32'h1f, RespSlvErr);
    chk("done idle", 1, doneLine);
    $display("test reset done");
    bus(1, RegMask, 32'h7, RespOkay);
    bus(1, RegCtrl, 32'h2, RespOkay);
    seed = lfsr(seed);
    arm(seed, 5'd6, 0);
    {start, pinDrv, userIoOe, userIoOut} <= {1'b0, seed[8:6]};
    waitFor(0);
    chk("done pulled", 0, doneLine);
    waitFor(1);
    chk("osc init", 1, n >= (NInit - 1) * OscDivCount && n <= (NInit + 1) * OscDivCount + 2);
    chk("bits", seed[5:0], got[5:0]);
    chk("user io", userIoOe ? userIoOut : pinDrv, userIoIn);
    chk("pin out", userIoOut, usrOut);
    chk("done line", 1, doneLine);
    chk("irq", 1, irq);
    bus(0, RegIrq, 1, RespOkay);
    bus(0, RegIrq, 0, RespOkay);
    bus(0, RegStatus, (NInit << 4) | 32'h12, RespOkay);
    $display("test oscillator done");
    arm(16'h0007, 5'd5, 0);
    bus(1, RegCtrl, 32'h1b, RespOkay);
    // Pin starts low so every pulse below is a rising edge
    {start, pinDrv, userIoOe} <= 3'b001;
    waitFor(0);
    repeat (60) @(posedge mclk);
    chk("no osc", 0, userMode);
    chk("pin free", 0, usrOe);
    chk("run", 32'h4000f, {nLoad[3:0], got});
    for (k = 0; k < 8; k++)
    begin
      chk("early", 0, userMode);
      pinDrv <= 1'b1;
      repeat (2) @(posedge mclk);
      pinDrv <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    waitFor(1);
    chk("user clk", 1, n < 6);
    $display("test user clock done");
    bus(0, RegIrq, 1, RespOkay);
    seed = lfsr(seed);
    arm(seed, 5'd6, 1);
    bus(1, RegCtrl, 32'h14, RespOkay);
    start <= 1'b0;
    for (k = 0; k < 100 && configStatusNOe !== 1'b1; k++) @(posedge mclk);
    for (n = 0; n < 100 && configStatusNOe === 1'b1; n++) @(posedge mclk);
    chk("low time", NErr, n);
    waitFor(0);
    waitFor(1);
    chk("resend", {4'h8, seed[5:4], seed[5:0]}, {nLoad[3:0], got[7:0]});
    bus(0, RegIrq, 7, RespOkay);
    $display("test error done");
    completeRun();
  end
endmodule // cis_sequencer_tb
